/* timer_mode_io_control_test.sv */
// self-checking bench for the mode and i/o control block
`include "tmc_map.vh"
module timer_mode_io_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [23:0] tmc_row_t;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, buffer_pair_sel, rsp;
  logic [2:0] pwm1_en, pwm2_en, phase_en, counter_run_bit;
  logic [5:0] phase_sel;
  logic [7:0] cmp_en, cap_en, clear_level, pin_level, pin_oe;
  logic [15:0] cap_edge, match_act;
  int fail_count = 0, n_tests = 0;
  // rows: address, write value, read-back value
  tmc_row_t rows [7] = '{24'h00_33F3, 24'h04_37C7, 24'h08_02C2,
    24'h0C_5858, 24'h10_1111, 24'h14_5A5A, 24'h18_A3A3};

  tmc_mode_ctrl tmc_mode_ctrl_i (.*);

  always #12.5 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1;
    s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // outputs lag the registers, so let them settle
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  initial begin
    #100000;
    fail_count++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(rd_d, i < 3 ? 32'h0000_00C0 : 32'h0000_0000);
    end
    foreach (rows[i]) begin
      wr(rows[i][23:16], {24'h0, rows[i][15:8]});
      chk(rsp, `TMC_RESP_OKAY);
      rd(rows[i][23:16]);
      chk(rd_d, {24'h0, rows[i][7:0]});
    end
    settle();
    chk(buffer_pair_sel, 2'h3);
    chk({pwm1_en, pwm2_en, phase_en}, 9'h10A);
    chk(phase_sel[3:2], 2'h3);
    chk(cmp_en[3:0], 4'h2);
    chk(pin_oe[3:0], 4'h2);
    chk({cap_en[3:0], cap_edge[1:0], match_act[3:2]}, 8'h15);
    chk({pin_level[1], clear_level[1]}, 2'h3);
    // level is frozen once the counter runs
    wr(`TMC_OFF_RUN, 32'h0000_0001);
    wr(`TMC_OFF_IOAB0, 32'h0000_0018);
    settle();
    chk({counter_run_bit[0], pin_level[1]}, 2'h3);
    wr(`TMC_OFF_RUN, 32'h0000_0000);
    settle();
    chk(pin_level[1], 1'h0);
    wr(`TMC_OFF_MODE0, 32'h0000_0003);
    settle();
    chk({buffer_pair_sel, cmp_en[3:2]}, 4'h3);
    wr(8'h40, 32'h0000_00FF);
    chk(rsp, `TMC_RESP_SLVERR);
    rd(8'h40);
    chk(rsp, `TMC_RESP_SLVERR);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(`TMC_OFF_MODE1);
    chk(rd_d, 32'h0000_00C0);
    results();
  end
endmodule // timer_mode_io_control_test

/* tmc_map.vh */
// register offsets, field positions and reset values of the mode block
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
`define TMC_OFF_MODE0     8'h00
`define TMC_OFF_MODE1     8'h04
`define TMC_OFF_MODE2     8'h08
`define TMC_OFF_IOAB0     8'h0C
`define TMC_OFF_IOCD0     8'h10
`define TMC_OFF_IOAB1     8'h14
`define TMC_OFF_IOAB2     8'h18
`define TMC_OFF_RUN       8'h1C
`define TMC_OFF_STATUS    8'h20
`define TMC_MODE_RST      8'hC0
`define TMC_MODE_FIXED    8'hC0
`define TMC_MODE_WMASK0   8'h3F
`define TMC_MODE_WMASK12  8'h0F
`define TMC_IO_RST        8'h00
`define TMC_BIT_BUF_B     5
`define TMC_BIT_BUF_A     4
`define TMC_MODE_NORMAL   3'b000
`define TMC_MODE_RSVD     3'b001
`define TMC_MODE_PWM1     3'b010
`define TMC_MODE_PWM2     3'b011
`define TMC_RESP_OKAY     2'b00
`define TMC_RESP_SLVERR   2'b10
`endif

/* tmc_mode_ctrl.v */
// channel mode and i/o control configuration for a three-channel timer
// How it works
// - the top two mode bits always read as one and ignore writes.
// - channel 0 mode bit 5 pairs b with d and mutes d's functions.
// - channel 0 mode bit 4 pairs a with c and mutes c's functions.
// - on channels 1 and 2 both buffer bits read zero and are fixed.
// - mode bits 2..0: normal, reserved, pwm 1, pwm 2, phase 1 to 4.
// - ch 0 has a/b and c/d i/o registers, ch 1 and 2 an a/b each.
// - an i/o code's initial level drives the pin while stopped.
// - in pwm mode 2 the i/o code sets the level applied on clear.
// - a c or d register used as a buffer ignores its i/o code.
// - a/b bits 7..4 pick b's role, 3..0 a's, reset zero, read/write.
// - c/d bits 7..4 pick d's role and 3..0 c's, reset zero.
// - code 0xyy with yy not 00 compares with initial level x, 1000/1001/101x capture.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`include "tmc_map.vh"
module tmc_mode_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // per channel decoded mode, index = channel
  output reg  [2:0]  pwm1_en,
  output reg  [2:0]  pwm2_en,
  output reg  [2:0]  phase_en,
  output reg  [5:0]  phase_sel,
  output reg  [2:0]  counter_run_bit,
  // per register function, order a0 b0 c0 d0 a1 b1 a2 b2
  output reg  [7:0]  cmp_en,
  output reg  [7:0]  cap_en,
  output reg  [15:0] cap_edge,
  output reg  [15:0] match_act,
  output reg  [7:0]  clear_level,
  output reg  [7:0]  pin_level,
  output reg  [7:0]  pin_oe,
  output reg  [1:0]  buffer_pair_sel
);

  // stored registers
  reg  [7:0]  mode_r [0:2];
  reg  [7:0]  io_ab_r [0:2];
  reg  [7:0]  io_cd0_r;
  reg  [2:0]  run_r;

  // write channel capture
  reg  [7:0]  aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg         w_have_r;
  reg         w_strb0_r;
  reg         wr_ok;
  wire        do_write;

  // read path
  reg  [31:0] rd_nxt;
  reg         rd_ok;

  // function decode
  reg  [31:0] func_code;
  reg  [7:0]  func_mute;
  integer     i;

  // a new write waits until the previous response is taken
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

  always @* begin
    wr_ok = 1'b1;
    case (aw_addr_r)
      `TMC_OFF_MODE0, `TMC_OFF_MODE1, `TMC_OFF_MODE2,
      `TMC_OFF_IOAB0, `TMC_OFF_IOCD0, `TMC_OFF_IOAB1,
      `TMC_OFF_IOAB2, `TMC_OFF_RUN, `TMC_OFF_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write channels, taken in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TMC_RESP_OKAY;
    end else begin
      // ready pulses for one cycle so a held valid is taken only once
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        aw_addr_r     <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb0_r    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        mode_r[i]  <= `TMC_MODE_RST;
        io_ab_r[i] <= `TMC_IO_RST;
      end
      io_cd0_r <= `TMC_IO_RST;
      run_r    <= 3'b000;
    // only byte lane 0 carries a register; other lanes are dropped
    end else if (do_write && w_strb0_r) begin
      case (aw_addr_r)
        `TMC_OFF_MODE0: mode_r[0] <= `TMC_MODE_FIXED |
                                     (w_data_r[7:0] & `TMC_MODE_WMASK0);
        `TMC_OFF_MODE1: mode_r[1] <= `TMC_MODE_FIXED |
                                     (w_data_r[7:0] & `TMC_MODE_WMASK12);
        `TMC_OFF_MODE2: mode_r[2] <= `TMC_MODE_FIXED |
                                     (w_data_r[7:0] & `TMC_MODE_WMASK12);
        `TMC_OFF_IOAB0: io_ab_r[0] <= w_data_r[7:0];
        `TMC_OFF_IOCD0: io_cd0_r   <= w_data_r[7:0];
        `TMC_OFF_IOAB1: io_ab_r[1] <= w_data_r[7:0];
        `TMC_OFF_IOAB2: io_ab_r[2] <= w_data_r[7:0];
        `TMC_OFF_RUN:   run_r      <= w_data_r[2:0];
        `TMC_OFF_STATUS: run_r <= run_r;
        default: run_r <= run_r;
      endcase
    end
  end

  // read data mux; unmapped offsets answer slverr with zero data
  always @* begin
    rd_ok  = 1'b1;
    rd_nxt = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      `TMC_OFF_MODE0:  rd_nxt[7:0] = mode_r[0];
      `TMC_OFF_MODE1:  rd_nxt[7:0] = mode_r[1];
      `TMC_OFF_MODE2:  rd_nxt[7:0] = mode_r[2];
      `TMC_OFF_IOAB0:  rd_nxt[7:0] = io_ab_r[0];
      `TMC_OFF_IOCD0:  rd_nxt[7:0] = io_cd0_r;
      `TMC_OFF_IOAB1:  rd_nxt[7:0] = io_ab_r[1];
      `TMC_OFF_IOAB2:  rd_nxt[7:0] = io_ab_r[2];
      `TMC_OFF_RUN:    rd_nxt[2:0] = run_r;
      `TMC_OFF_STATUS: rd_nxt[7:0] = pin_level;
      default:         rd_ok = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TMC_RESP_OKAY;
    end else begin
      // the answer stands until rready so no read data is lost
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_nxt;
        s_axi_rresp   <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // gather the eight function codes and their buffer mute bits
  always @* begin
    func_code = {io_ab_r[2], io_ab_r[1], io_cd0_r, io_ab_r[0]};
    func_mute = {4'b0000, mode_r[0][`TMC_BIT_BUF_B],
                 mode_r[0][`TMC_BIT_BUF_A], 2'b00};
  end

  // per-channel mode decode, one copy per channel
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_mode
      wire [2:0] mode_lo = mode_r[c][2:0];
      // a prohibited mode (bit 3 set) falls back to normal operation so
      // a bad write cannot start pwm or phase counting
      wire       mode_ok = !mode_r[c][3];
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          pwm1_en[c]          <= 1'b0;
          pwm2_en[c]          <= 1'b0;
          phase_en[c]         <= 1'b0;
          phase_sel[2*c +: 2] <= 2'b00;
          counter_run_bit[c]  <= 1'b0;
        end else begin
          pwm1_en[c]          <= mode_ok && mode_lo == `TMC_MODE_PWM1;
          pwm2_en[c]          <= mode_ok && mode_lo == `TMC_MODE_PWM2;
          phase_en[c]         <= mode_ok && mode_lo[2];
          phase_sel[2*c +: 2] <= mode_lo[1:0];
          counter_run_bit[c]  <= run_r[c];
        end
      end
    end
  endgenerate

  // buffer pairing exists on channel 0 only
  always @(posedge clk or posedge rst) begin
    if (rst)
      buffer_pair_sel <= 2'b00;
    else
      buffer_pair_sel <= {mode_r[0][`TMC_BIT_BUF_B],
                          mode_r[0][`TMC_BIT_BUF_A]};
  end

  // per register function decode
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_func
      localparam integer CH = (g < 4) ? 0 : ((g < 6) ? 1 : 2);
      wire [3:0] code = func_code[4*g +: 4];
      wire       run  = run_r[CH];
      wire       pw2  = !mode_r[CH][3] &&
                        mode_r[CH][2:0] == `TMC_MODE_PWM2;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_en[g]          <= 1'b0;
          cap_en[g]          <= 1'b0;
          cap_edge[2*g +: 2] <= 2'b00;
          match_act[2*g +: 2] <= 2'b00;
          clear_level[g]     <= 1'b0;
          pin_level[g]       <= 1'b0;
          pin_oe[g]          <= 1'b0;
        end else if (func_mute[g]) begin
          cmp_en[g]          <= 1'b0;
          cap_en[g]          <= 1'b0;
          cap_edge[2*g +: 2] <= 2'b00;
          match_act[2*g +: 2] <= 2'b00;
          clear_level[g]     <= 1'b0;
          pin_oe[g]          <= 1'b0;
          // pin_level holds so the pin does not glitch when pairing
          // is switched on or off
        end else begin
          cmp_en[g]  <= !code[3] && code[1:0] != 2'b00;
          cap_en[g]  <= code[3:2] == 2'b10;
          // 01 rising, 10 falling, 11 both edges
          cap_edge[2*g +: 2] <= code[1] ? 2'b11 :
                                (code[0] ? 2'b10 : 2'b01);
          // 00 none, 01 low, 10 high, 11 toggle at match
          match_act[2*g +: 2] <= code[3] ? 2'b00 : code[1:0];
          pin_oe[g]  <= !code[3] && code[1:0] != 2'b00;
          clear_level[g] <= pw2 ? code[2] : 1'b0;
          if (!run)
            pin_level[g] <= code[2];
        end
      end
    end
  endgenerate

endmodule // tmc_mode_ctrl

/* tmc_mode_ctrl_assertions.sv */
// port level checks for the mode and i/o control block
module tmc_mode_ctrl_chk (
  // clock and reset
  input logic        clk,
  input logic        rst,
  // bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  // decoded outputs
  input logic [2:0]  pwm1_en,
  input logic [2:0]  pwm2_en,
  input logic [2:0]  phase_en,
  input logic [7:0]  cmp_en,
  input logic [7:0]  cap_en,
  input logic [15:0] cap_edge,
  input logic [15:0] match_act,
  input logic [7:0]  clear_level,
  input logic [7:0]  pin_oe,
  input logic [1:0]  buffer_pair_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_buf_c_mute: assert property (
    buffer_pair_sel[0] |-> !cmp_en[2] && !cap_en[2] && !pin_oe[2])
    else $error("c active while buffered");
  chk_buf_d_mute: assert property (
    buffer_pair_sel[1] |-> !cmp_en[3] && !cap_en[3] && !pin_oe[3])
    else $error("d active while buffered");
  chk_mode_onehot: assert property (
    (pwm1_en & pwm2_en) == 3'h0 && ((pwm1_en | pwm2_en) & phase_en) == 3'h0)
    else $error("two modes at once");
  chk_role_excl: assert property ((cmp_en & cap_en) == 8'h00)
    else $error("compare and capture together");
  chk_cap_edge_a: assert property (
    cap_en[0] |-> cap_edge[1:0] != 2'h0)
    else $error("capture without edge");
  chk_clear_pwm2: assert property (
    (pwm2_en[0] || clear_level[3:0] == 4'h0) &&
    (pwm2_en[1] || clear_level[5:4] == 2'h0) &&
    (pwm2_en[2] || clear_level[7:6] == 2'h0))
    else $error("clear level outside pwm 2");
  chk_oe_cmp_b: assert property (
    pin_oe[1] |-> cmp_en[1] && match_act[3:2] != 2'h0)
    else $error("pin driven while disabled");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
endmodule // tmc_mode_ctrl_chk

bind tmc_mode_ctrl tmc_mode_ctrl_chk tmc_mode_ctrl_chk_i (.*);
